// [core/psc_top.v]
// Functional notes
// RULE1 - Latch RXD3..1 straps as address bits 0..2
// RULE2 - Latch RXD0 strap as duplex, reg0 bit8
// RULE3 - Latch receive-error strap as isolate setting
// RULE4 - Latch receive-valid strap as mode bit 2
// RULE5 - Latch COL, CRS straps as mode bits 0,1
// RULE6 - Latch LED0 strap as autoneg, reg0 bit12
// RULE7 - MII four data outputs, RMII two only; this implementation drives all four in RMII, RXD3..2 low
// RULE8 - Valid pin: MII valid, RMII carrier-valid
// RULE9 - Error output both modes, clock in MII
// RULE10 - System supplies 25/50 MHz reference, 50ppm
// RULE11 - Enhanced RMII outputs generated 50 MHz reference
// RULE12 - Management data synchronous to external clock
// RULE13 - Straps undriven in reset, outputs after
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "psc_map.vh"
module psc_top (
  input  wire        i_clk,        // Core clock, 25 MHz
  input  wire        i_arst_n,     // Async reset, active low
  input  wire        i_psel,       // APB select
  input  wire        i_penable,    // APB enable
  input  wire        i_pwrite,     // APB direction
  input  wire [11:0] i_paddr,      // APB byte address
  input  wire [31:0] i_pwdata,     // APB write data
  output reg         o_pready,     // APB ready
  output reg  [31:0] o_prdata,     // APB read data
  output reg         o_pslverr,    // APB error
  input  wire [3:0]  i_rx_data,    // Receive nibble from core
  input  wire        i_rx_valid,   // Receive data valid from core
  input  wire        i_rx_crs,     // Carrier sense from core
  input  wire        i_rx_col,     // Collision from core
  input  wire        i_rx_err,     // Receive error from core
  input  wire        i_link_up,    // Link status for LED
  input  wire [3:0]  i_rxd_in,     // Receive data pins, input
  output reg  [3:0]  o_rxd_out,    // Receive data pins, output
  output reg  [3:0]  o_rxd_oe,     // Receive data pins, enable
  input  wire        i_rxv_in,     // Receive valid pin, input
  output reg         o_rxv_out,    // Receive valid pin, output
  output reg         o_rxv_oe,     // Receive valid pin, enable
  input  wire        i_rxe_in,     // Receive error pin, input
  output reg         o_rxe_out,    // Receive error pin, output
  output reg         o_rxe_oe,     // Receive error pin, enable
  input  wire        i_col_in,     // Collision pin, input
  output reg         o_col_out,    // Collision pin, output
  output reg         o_col_oe,     // Collision pin, enable
  input  wire        i_crs_in,     // Carrier pin, input
  output reg         o_crs_out,    // Carrier pin, output
  output reg         o_crs_oe,     // Carrier pin, enable
  input  wire        i_led0_in,    // LED0 pin, input
  output reg         o_led0_out,   // LED0 pin, output
  output reg         o_led0_oe,    // LED0 pin, enable
  output reg         o_rxc,        // MII receive clock out
  output reg         o_refclk_en,  // Enable 50 MHz reference out
  input  wire        i_mdc,        // Management clock pin
  input  wire        i_mdio_in,    // Management data, input
  output reg         o_mdio_out,   // Management data, output
  output reg         o_mdio_oe     // Management data, enable
);

  localparam S_SYNC = 2'h0;
  localparam S_LAT  = 2'h1;
  localparam S_RUN  = 2'h2;

  localparam M_IDLE = 2'h0;
  localparam M_HDR  = 2'h1;
  localparam M_RD   = 2'h2;
  localparam M_WR   = 2'h3;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire [`PSC_NSYNC-1:0] pins_s;

  psc_sync #(
    .W (`PSC_NSYNC)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      ({i_mdio_in, i_mdc, i_led0_in, i_crs_in, i_col_in,
                i_rxe_in, i_rxv_in, i_rxd_in}),
    .o_q      (pins_s)
  );

  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  reg  [1:0]  st_q;
  reg  [2:0]  wait_q;
  reg  [2:0]  addr_q;
  reg  [2:0]  mode_q;
  reg  [15:0] reg0_q;
  reg  [1:0]  ctrl_q;
  reg         done_q;
  wire        rmii = (mode_q == `PSC_MODE_RMII);
  wire        iso  = reg0_q[`PSC_R0_ISOLATE];
  wire        drv  = (st_q == S_RUN) && !iso;

  // Management engine state
  reg  [1:0]  ms_q;
  reg  [5:0]  pre_q;
  reg  [4:0]  bc_q;
  reg  [13:0] hdr_q;
  reg  [15:0] sh_q;
  reg         mdc_d_q;
  wire        mdc_s  = pins_s[`PSC_P_MDC];
  wire        mdio_s = pins_s[`PSC_P_MDIO];
  wire        rise   = mdc_s && !mdc_d_q;   // RULE12
  wire        fall   = !mdc_s && mdc_d_q;   // RULE12
  wire [13:0] hdr_n  = {hdr_q[12:0], mdio_s};
  wire        hit    = (hdr_n[13:12] == `PSC_ST_CODE) &&
                       (hdr_n[9:5] == {`PSC_ADDR_HI, addr_q});
  wire        wr_end = (ms_q == M_WR) && rise && (bc_q == `PSC_WR_LAST);
  wire        wr_r0  = wr_end && (hdr_q[4:0] == `PSC_REG0);
  wire [15:0] wr_val = {sh_q[14:0], mdio_s};

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q   <= S_SYNC;
      wait_q <= 3'h0;
      addr_q <= 3'h0;
      mode_q <= 3'h0;
      reg0_q <= `PSC_R0_RST;
      done_q <= 1'b0;
    end else begin
      case (st_q)
        S_SYNC: begin
          wait_q <= wait_q + 3'h1;
          if (wait_q == `PSC_SYNC_CYC) begin
            st_q <= S_LAT;
          end
        end
        S_LAT: begin
          addr_q <= {pins_s[`PSC_P_RXD1], pins_s[`PSC_P_RXD2],
                     pins_s[`PSC_P_RXD3]};                      // RULE1
          reg0_q[`PSC_R0_DUPLEX]  <= pins_s[`PSC_P_RXD0];      // RULE2
          reg0_q[`PSC_R0_ISOLATE] <= pins_s[`PSC_P_RXERR];     // RULE3
          mode_q[2] <= pins_s[`PSC_P_RXVALID];                 // RULE4
          mode_q[1] <= pins_s[`PSC_P_CRS];                     // RULE5
          mode_q[0] <= pins_s[`PSC_P_COL];                     // RULE5
          reg0_q[`PSC_R0_AUTONEG] <= pins_s[`PSC_P_LED0];      // RULE6
          done_q <= 1'b1;
          st_q   <= S_RUN;
        end
        S_RUN: begin
          if (wr_r0) begin
            reg0_q[`PSC_R0_AUTONEG] <= wr_val[`PSC_R0_AUTONEG];
            reg0_q[`PSC_R0_ISOLATE] <= wr_val[`PSC_R0_ISOLATE];
            reg0_q[`PSC_R0_DUPLEX]  <= wr_val[`PSC_R0_DUPLEX];
          end else if (ctrl_q[`PSC_CT_ISO_REL]) begin
            reg0_q[`PSC_R0_ISOLATE] <= 1'b0;
          end
        end
        default: begin
          st_q <= S_SYNC;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Receive pin drive
  // ------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rxd_out   <= 4'h0;
      o_rxd_oe    <= 4'h0;
      o_rxv_out   <= 1'b0;
      o_rxv_oe    <= 1'b0;
      o_rxe_out   <= 1'b0;
      o_rxe_oe    <= 1'b0;
      o_col_out   <= 1'b0;
      o_col_oe    <= 1'b0;
      o_crs_out   <= 1'b0;
      o_crs_oe    <= 1'b0;
      o_led0_out  <= 1'b1;
      o_led0_oe   <= 1'b0;
      o_rxc       <= 1'b0;
      o_refclk_en <= 1'b0;
    end else begin
      o_rxd_oe   <= {4{drv}};                                  // RULE13
      o_rxv_oe   <= drv;                                       // RULE13
      o_rxe_oe   <= drv;                                       // RULE13
      o_col_oe   <= drv && !rmii;                              // RULE13
      o_crs_oe   <= drv && !rmii;                              // RULE13
      o_led0_oe  <= (st_q == S_RUN);                           // RULE13
      o_led0_out <= !i_link_up;
      if (rmii) begin
        o_rxd_out  <= {2'h0, i_rx_data[1:0]};                  // RULE7
        o_rxv_out  <= i_rx_crs | i_rx_valid;                   // RULE8
        o_rxc      <= 1'b0;
      end else begin
        o_rxd_out  <= i_rx_data;                               // RULE7
        o_rxv_out  <= i_rx_valid;                              // RULE8
        o_rxc      <= drv ? !o_rxc : 1'b0;                     // RULE9
      end
      o_rxe_out   <= i_rx_err;                                 // RULE9
      o_col_out   <= i_rx_col;
      o_crs_out   <= i_rx_crs;
      o_refclk_en <= (st_q == S_RUN) && rmii && ctrl_q[`PSC_CT_ENH]; // RULE11
    end
  end

  // ------------------------------------------------------------
  // Management frame engine
  // ------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mdc_d_q    <= 1'b0;
      ms_q       <= M_IDLE;
      pre_q      <= 6'h00;
      bc_q       <= 5'h00;
      hdr_q      <= 14'h0000;
      sh_q       <= 16'h0000;
      o_mdio_out <= 1'b0;
      o_mdio_oe  <= 1'b0;
    end else begin
      mdc_d_q <= mdc_s;
      case (ms_q)
        M_IDLE: begin
          o_mdio_oe <= 1'b0;
          if (rise && (st_q == S_RUN)) begin                  // RULE12
            if (mdio_s) begin
              if (pre_q != `PSC_PRE_LEN) begin
                pre_q <= pre_q + 6'h01;
              end
            end else if (pre_q == `PSC_PRE_LEN) begin
              hdr_q <= hdr_n;
              bc_q  <= 5'h01;
              ms_q  <= M_HDR;
              pre_q <= 6'h00;
            end else begin
              pre_q <= 6'h00;
            end
          end
        end
        M_HDR: begin
          if (rise) begin
            hdr_q <= hdr_n;
            bc_q  <= bc_q + 5'h01;
            if (bc_q[3:0] == `PSC_HDR_LAST) begin
              bc_q <= 5'h00;
              sh_q <= (hdr_n[4:0] == `PSC_REG0) ? reg0_q : 16'h0000;
              if (!hit) begin
                ms_q <= M_IDLE;
              end else if (hdr_n[11:10] == `PSC_OP_RD) begin
                ms_q <= M_RD;
              end else if (hdr_n[11:10] == `PSC_OP_WR) begin
                ms_q <= M_WR;
              end else begin
                ms_q <= M_IDLE;
              end
            end
          end
        end
        M_RD: begin
          if (fall) begin                                      // RULE12
            bc_q <= bc_q + 5'h01;
            if (bc_q == 5'h00) begin
              o_mdio_oe <= 1'b0;
            end else if (bc_q == 5'h01) begin
              o_mdio_oe  <= 1'b1;
              o_mdio_out <= 1'b0;
            end else if (bc_q == `PSC_RD_LAST) begin
              o_mdio_oe <= 1'b0;
              ms_q      <= M_IDLE;
            end else begin
              o_mdio_out <= sh_q[15];
              sh_q       <= {sh_q[14:0], 1'b0};
            end
          end
        end
        M_WR: begin
          if (rise) begin                                      // RULE12
            bc_q <= bc_q + 5'h01;
            sh_q <= wr_val;
            if (bc_q == `PSC_WR_LAST) begin
              ms_q <= M_IDLE;
            end
          end
        end
        default: begin
          ms_q <= M_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // APB slave, one wait state
  // ------------------------------------------------------------
  wire [31:0] status = {21'h0, rmii, done_q, reg0_q[`PSC_R0_AUTONEG], mode_q,
                        reg0_q[`PSC_R0_ISOLATE], reg0_q[`PSC_R0_DUPLEX], addr_q};
  wire        acc    = i_psel && i_penable && !o_pready;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
      ctrl_q    <= `PSC_CTRL_RST;
    end else begin
      o_pready  <= acc;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
      ctrl_q[`PSC_CT_ISO_REL] <= 1'b0;
      if (acc) begin
        case (i_paddr)
          `PSC_OFS_STATUS: begin
            o_prdata  <= status;
            o_pslverr <= i_pwrite;
          end
          `PSC_OFS_CTRL: begin
            o_prdata <= {30'h0, 1'b0, ctrl_q[`PSC_CT_ENH]};
            if (i_pwrite) begin
              ctrl_q <= i_pwdata[1:0];
            end
          end
          `PSC_OFS_MREG0: begin
            o_prdata  <= {16'h0000, reg0_q};
            o_pslverr <= i_pwrite;
          end
          default: begin
            o_pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// [core/psc_map.vh]
`ifndef PSC_MAP_VH
`define PSC_MAP_VH

// APB register byte offsets
`define PSC_OFS_STATUS    12'h000
`define PSC_OFS_CTRL      12'h004
`define PSC_OFS_MREG0     12'h008

// Status register fields
`define PSC_ST_ADDR_LSB   0
`define PSC_ST_DUPLEX     3
`define PSC_ST_ISOLATE    4
`define PSC_ST_MODE_LSB   5
`define PSC_ST_AUTONEG    8
`define PSC_ST_DONE       9
`define PSC_ST_RMII       10

// Control register fields and reset value
`define PSC_CT_ENH        0
`define PSC_CT_ISO_REL    1
`define PSC_CTRL_RST      2'h0

// Management register 0 fields
`define PSC_R0_AUTONEG    12
`define PSC_R0_ISOLATE    10
`define PSC_R0_DUPLEX     8
`define PSC_R0_RST        16'h0000

// Mode select code that picks RMII
`define PSC_MODE_RMII     3'h1

// Strap and management pin index in synchroniser vector
`define PSC_P_RXD0        0
`define PSC_P_RXD1        1
`define PSC_P_RXD2        2
`define PSC_P_RXD3        3
`define PSC_P_RXVALID     4
`define PSC_P_RXERR       5
`define PSC_P_COL         6
`define PSC_P_CRS         7
`define PSC_P_LED0        8
`define PSC_P_MDC         9
`define PSC_P_MDIO        10
`define PSC_NSYNC         11

// Last wait count after reset release before straps are taken
`define PSC_SYNC_CYC      3'h3

// Management frame figures
`define PSC_PRE_LEN       6'h20
`define PSC_HDR_LAST      4'hD
`define PSC_RD_LAST       5'h12
`define PSC_WR_LAST       5'h11
`define PSC_ST_CODE       2'h1
`define PSC_OP_RD         2'h2
`define PSC_OP_WR         2'h1
`define PSC_ADDR_HI       2'h0
`define PSC_REG0          5'h00

`endif

// [core/psc_sync.v]
`timescale 1ns/1ps
module psc_sync #(
  parameter W = 11
) (
  input  wire         i_clk,    // Core clock
  input  wire         i_arst_n, // Async reset, active low
  input  wire [W-1:0] i_d,      // Asynchronous inputs
  output wire [W-1:0] o_q       // Synchronised outputs
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= i_d[g];
          s2_q <= s1_q;
        end
      end
      assign o_q[g] = s2_q;
    end
  endgenerate

endmodule

// [testbench/psc_top_properties.sv]
`timescale 1ns/1ps
module psc_props (
  input wire       i_clk,      // Core clock
  input wire       i_arst_n,   // Async reset
  input wire [3:0] i_rx_data,  // Core nibble
  input wire       i_rx_valid, // Core valid
  input wire       i_rx_crs,   // Core carrier
  input wire       i_rx_err,   // Core error
  input wire       i_mdc,      // Mgmt clock
  input wire [3:0] o_rxd_out,  // Data pins
  input wire [3:0] o_rxd_oe,   // Data enables
  input wire       o_rxv_out,  // Valid pin
  input wire       o_rxv_oe,   // Valid enable
  input wire       o_rxe_out,  // Error pin
  input wire       o_rxe_oe,   // Error enable
  input wire       o_col_oe,   // Collision enable
  input wire       o_led0_oe,  // LED enable
  input wire       o_rxc,      // Receive clock
  input wire       o_mdio_out  // Mgmt data
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_oe_hold;
    $rose(i_arst_n) |-> (o_rxd_oe == 4'h0 && !o_rxv_oe && !o_rxe_oe && !o_led0_oe)[*4];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pins driven during strap");
  property p_rmii_hi;
    o_rxd_oe == 4'hF && !o_col_oe |-> o_rxd_out[3:2] == 2'h0;
  endproperty
  a_rmii_hi: assert property (p_rmii_hi) else $error("upper nibble in rmii");
  property p_mii_data;
    o_col_oe && $past(o_col_oe) |-> o_rxd_out == $past(i_rx_data);
  endproperty
  a_mii_data: assert property (p_mii_data) else $error("mii data wrong");
  property p_rmii_dv;
    o_rxv_oe && $past(o_rxv_oe) && !o_col_oe |->
      o_rxv_out == ($past(i_rx_crs) | $past(i_rx_valid));
  endproperty
  a_rmii_dv: assert property (p_rmii_dv) else $error("rmii valid wrong");
  property p_mii_dv;
    o_col_oe && $past(o_col_oe) |-> o_rxv_out == $past(i_rx_valid);
  endproperty
  a_mii_dv: assert property (p_mii_dv) else $error("mii valid wrong");
  property p_err;
    o_rxe_oe && $past(o_rxe_oe) |-> o_rxe_out == $past(i_rx_err);
  endproperty
  a_err: assert property (p_err) else $error("error pin wrong");
  property p_rxc;
    o_col_oe ##1 o_col_oe |-> o_rxc != $past(o_rxc);
  endproperty
  a_rxc: assert property (p_rxc) else $error("rx clock stuck");
  property p_mdio;
    $changed(o_mdio_out) |-> !i_mdc;
  endproperty
  a_mdio: assert property (p_mdio) else $error("mdio moved on high clock");
  cover property (o_col_oe);
  cover property (o_rxd_oe[0] && !o_col_oe);
  cover property ($changed(o_mdio_out));
endmodule
bind psc_top psc_props i_props (.*);

// [testbench/psc_mac_model.sv]
`timescale 1ns/1ps
module psc_mac_model (
  input  wire [8:0] i_pull, // Strap resistor levels
  input  wire [8:0] i_out,  // Device drive values
  input  wire [8:0] i_oe,   // Device drive enables
  output wire [8:0] o_pin   // Resolved pin levels
);
  // Released pins sit at resistor level
  assign o_pin = (i_oe & i_out) | (~i_oe & i_pull);
endmodule

// [testbench/psc_top_tb.sv]
`timescale 1ns/1ps
`include "psc_map.vh"
module psc_top_tb;
  logic        i_clk = 0, i_arst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0;
  logic [3:0]  i_rx_data = 0;
  logic        i_rx_valid = 0, i_rx_crs = 0, i_rx_col = 0, i_rx_err = 0, i_link_up = 0;
  logic        i_mdc = 1, mdio_h = 1;
  logic [8:0]  pull = 0;
  wire  [8:0]  pin, pout, poe;
  wire         o_pready, o_pslverr, o_rxc, o_refclk_en, o_mdio_out, o_mdio_oe;
  wire  [31:0] o_prdata;
  logic [32:0] q[$];
  int          fails = 0, check_count = 0;
  // --------------------------------
  // Design and pin model
  // --------------------------------
  psc_top i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_rx_data(i_rx_data), .i_rx_valid(i_rx_valid),
    .i_rx_crs(i_rx_crs), .i_rx_col(i_rx_col), .i_rx_err(i_rx_err), .i_link_up(i_link_up),
    .i_rxd_in(pin[3:0]), .o_rxd_out(pout[3:0]), .o_rxd_oe(poe[3:0]), .i_rxv_in(pin[4]),
    .o_rxv_out(pout[4]), .o_rxv_oe(poe[4]), .i_rxe_in(pin[5]), .o_rxe_out(pout[5]),
    .o_rxe_oe(poe[5]), .i_col_in(pin[6]), .o_col_out(pout[6]), .o_col_oe(poe[6]),
    .i_crs_in(pin[7]), .o_crs_out(pout[7]), .o_crs_oe(poe[7]), .i_led0_in(pin[8]),
    .o_led0_out(pout[8]), .o_led0_oe(poe[8]), .o_rxc(o_rxc), .o_refclk_en(o_refclk_en),
    .i_mdc(i_mdc), .i_mdio_in(o_mdio_oe ? o_mdio_out : mdio_h), .o_mdio_out(o_mdio_out),
    .o_mdio_oe(o_mdio_oe));
  psc_mac_model i_mac (.i_pull(pull), .i_out(pout), .i_oe(poe), .o_pin(pin));
  initial forever #20 i_clk = ~i_clk;
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge i_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    q.push_back(e);
    @(posedge i_clk);
    i_penable <= 1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic mbit(input logic b, output logic r);
    i_mdc <= 0;
    mdio_h <= b;
    repeat (4) @(posedge i_clk);
    i_mdc <= 1;
    repeat (4) @(posedge i_clk);
    r = o_mdio_oe ? o_mdio_out : mdio_h;
  endtask
  always @(posedge i_clk)
    if (i_psel && i_penable && o_pready === 1'b1)
      chk({o_pslverr, i_pwrite ? 32'h0 : o_prdata}, q.pop_front());
  initial begin
    repeat (10000) @(posedge i_clk);
    fails++;
    final_report();
  end
  // --------------------------------
  // Strap, register and pin tests
  // --------------------------------
  initial begin
    logic [8:0] s;
    logic [2:0] m;
    logic [31:0] st;
    logic [15:0] r0;
    logic [17:0] rd;
    logic [45:0] hdr;
    logic [15:0] w;
    logic [63:0] wf;
    logic r, c, rmii;
    void'($urandom(32'h871825C9));
    for (int i = 0; i < 4; i++) begin
      s = $urandom;
      s[5] = (i == 3);
      {s[4], s[7], s[6]} = i[0] ? 3'h5 : 3'h1;
      m = {s[4], s[7], s[6]};
      rmii = (m == `PSC_MODE_RMII);
      st = {21'h0, rmii, 1'b1, s[8], m, s[5], s[0], s[1], s[2], s[3]};
      r0 = {3'h0, s[8], 1'b0, s[5], 1'b0, s[0], 8'h00};
      @(posedge i_clk);
      i_arst_n <= 0;
      pull <= s;
      repeat (3) @(posedge i_clk);
      chk(poe, 9'h0);
      i_arst_n <= 1;
      repeat (12) @(posedge i_clk);
      apb(0, `PSC_OFS_STATUS, 0, {1'b0, st});
      apb(0, `PSC_OFS_MREG0, 0, {17'h0, r0});
      apb(1, `PSC_OFS_STATUS, 32'hFFFFFFFF, {1'b1, 32'h0});
      apb(0, 12'h00C, 0, {1'b1, 32'h0});
      hdr = {32'hFFFFFFFF, 4'h6, 2'h0, st[2:0], 5'h00};
      for (int k = 45; k >= 0; k--) mbit(hdr[k], r);
      for (int k = 0; k < 18; k++) begin
        mbit(1'b1, r);
        rd = {rd[16:0], r};
      end
      chk(rd, {2'h2, r0});
      mbit(1'b1, r);
      chk(o_mdio_oe, 1'b0);
      chk(poe[3:0], s[5] ? 4'h0 : 4'hF);
      w = $urandom;
      wf = {32'hFFFFFFFF, 4'h5, 2'h0, st[2:0], 5'h00, 2'h2, w};
      for (int k = 63; k >= 0; k--) mbit(wf[k], r);
      apb(0, `PSC_OFS_MREG0, 0, {17'h0, w & 16'h1500});
      apb(1, `PSC_OFS_CTRL, 32'h3, 33'h0);
      apb(0, `PSC_OFS_CTRL, 0, 33'h1);
      chk(o_refclk_en, rmii);
      repeat (20) begin
        @(posedge i_clk);
        {i_rx_data, i_rx_valid, i_rx_crs, i_rx_col, i_rx_err, i_link_up} <= $urandom;
        @(posedge i_clk);
        c = o_rxc;
        #1;
        chk(pout[3:0], rmii ? {2'h0, i_rx_data[1:0]} : i_rx_data);
        chk({poe[4], pout[4]}, {1'b1, rmii ? i_rx_crs | i_rx_valid : i_rx_valid});
        chk({poe[5], pout[5]}, {1'b1, i_rx_err});
        chk({poe[6], o_rxc}, {!rmii, !rmii & !c});
        chk({poe[8:6], pout[8:6]}, {1'b1, !rmii, !rmii, !i_link_up, i_rx_crs, i_rx_col});
      end
    end
    final_report();
  end
endmodule
